/* File: core/warning_status_pulse_outputs.sv */
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module warning_status_pulse_outputs
    import warn_pkg::*;
#(
    parameter int FAN_CYC = FAN_STOP_CYC,  // fan stop qualification
    parameter int SEC_CNT = SEC_CYC,       // one second of clocks
    parameter int RES_W   = 24             // encoder resolution width
) (
    // clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // axi4-lite write
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // conditions from control core, same clock
    input  wire warn_cond_t         cond,
    input  wire drive_stat_t        stat,
    // feedback position edges, same clock
    input  wire logic               fb_step,
    input  wire logic               fb_dir,
    input  wire logic               fb_index,
    // outputs
    output logic                    warning_out_first,
    output logic                    warning_out_second,
    output drive_stat_t             stat_out,
    output pulse_pins_t             pins
);
    initial begin
        if (FAN_CYC < 1 || SEC_CNT < 1 || RES_W < 4 || RES_W > 32)
            $error("bad parameter");
    end

    // configuration registers
    logic [3:0]  sel_first_reg;    // output 1 select code
    logic [3:0]  sel_second_reg;   // output 2 select code
    logic [3:0]  latch_reg;        // 0 unlimited, 1..10 seconds
    logic [10:0] mask_reg;         // 1 masks detection
    logic [15:0] numer_reg;        // output pulses numerator
    logic [15:0] denom_reg;        // divider denominator
    logic [RES_W-1:0] res_reg;     // encoder resolution
    logic [NUM_WARN-1:0] raw;      // detected conditions
    logic [NUM_WARN-1:0] warn_reg; // latched warnings
    logic [NUM_WARN-1:0] en;       // unmasked enable

    // raw detection
    logic [31:0] fan_cnt_reg;
    always_ff @(posedge aclk) begin
        // fan must be stopped continuously for the full time
        if (!aresetn || !cond.fan_stopped) begin
            fan_cnt_reg <= '0;
        end else if (fan_cnt_reg < 32'(FAN_CYC)) begin
            fan_cnt_reg <= fan_cnt_reg + 32'h1;
        end
    end

    always_comb begin
        raw[W_OVERLOAD]   = cond.load_pct >= LOAD_WARN_PCT;
        raw[W_REGEN]      = cond.regen_pct >= LOAD_WARN_PCT;
        raw[W_BATTERY]    = cond.batt_mv <= BATT_WARN_MV;
        raw[W_FAN]        = fan_cnt_reg >= 32'(FAN_CYC);
        raw[W_ENC_COMM]   = cond.enc_comm_over;
        raw[W_SCALE_COMM] = cond.scale_comm_over;
        raw[W_ENC_HEAT]   = cond.enc_overheat;
        raw[W_SCALE_ERR]  = cond.scale_alarm;
        raw[W_OSC]        = cond.osc_detected;
        raw[W_LIFE]       = cond.life_short;
    end

    // one second tick shared by every hold timer
    logic [31:0] sec_cnt_reg;
    logic        sec_tick;
    assign sec_tick = sec_cnt_reg == 32'(SEC_CNT - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn || sec_tick) begin
            sec_cnt_reg <= '0;
        end else begin
            sec_cnt_reg <= sec_cnt_reg + 32'h1;
        end
    end

    // per warning latch and hold timer
    genvar gi;
    generate
        for (gi = 0; gi < NUM_WARN; gi++) begin : g_warn
            logic [3:0] hold_reg;   // seconds remaining after the cause clears
            logic       forever_w;  // never times out
            assign en[gi] = !mask_reg[MASK_BIT[gi]];
            assign forever_w = (gi == W_BATTERY) || (gi == W_LIFE)
                            || (latch_reg == LATCH_UNLIMITED);
            always_ff @(posedge aclk) begin
                // cause present restarts the hold; masking drops it at once
                if (!aresetn || !en[gi]) begin
                    warn_reg[gi] <= 1'b0;
                    hold_reg     <= 4'h0;
                end else if (raw[gi]) begin
                    warn_reg[gi] <= 1'b1;
                    hold_reg     <= latch_reg;
                end else if (warn_reg[gi] && !forever_w && sec_tick) begin
                    if (hold_reg <= 4'h1) begin
                        warn_reg[gi] <= 1'b0;
                    end
                    hold_reg <= hold_reg - 4'h1;
                end
            end
        end
    endgenerate

    // output select; out of range codes read as no warning
    function automatic logic pick(input logic [3:0] code, input logic [NUM_WARN-1:0] w);
        if (code == 4'h0) begin
            return |w;
        end else if (code <= 4'(NUM_WARN)) begin
            return w[code - 4'h1];
        end else begin
            return 1'b0;
        end
    endfunction

    // warning and status outputs registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            warning_out_first  <= 1'b0;
            warning_out_second <= 1'b0;
            stat_out           <= '0;
        end else begin
            warning_out_first  <= pick(sel_first_reg, warn_reg);
            warning_out_second <= pick(sel_second_reg, warn_reg);
            stat_out.pos_cmd         <= stat.pos_cmd;
            stat_out.speed_limit     <= stat.speed_limit;
            stat_out.alarm_clearable <= stat.alarm_clearable;
            stat_out.speed_cmd       <= stat.speed_cmd;
            stat_out.servo_on        <= stat.servo_on;
        end
    end

    // divider: accumulate numerator per feedback step, emit on denominator
    logic [16:0] acc_reg;
    logic [7:0]  pend_reg;     // pending output edges, signed by dir_reg
    logic        dir_reg;
    logic [7:0]  gap_reg;      // edge spacing counter
    logic [1:0]  quad_reg;     // gray quadrature state
    logic        emit;
    logic        add_one;
    assign add_one = fb_step && ({1'b0, acc_reg[15:0]} + {1'b0, numer_reg} >= {1'b0, denom_reg});
    // pending only drains toward the latest direction; a reversal starts afresh
    assign emit = (pend_reg != 8'h0) && (gap_reg == 8'h0);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_reg  <= '0;
            pend_reg <= '0;
            dir_reg  <= 1'b0;
        end else begin
            if (fb_step) begin
                acc_reg <= add_one ? 17'({1'b0, acc_reg[15:0]} + {1'b0, numer_reg} - {1'b0, denom_reg})
                                   : 17'({1'b0, acc_reg[15:0]} + {1'b0, numer_reg});
            end
            if (fb_step && fb_dir != dir_reg) begin
                dir_reg  <= fb_dir;
                pend_reg <= add_one ? 8'h1 : 8'h0;
            end else if (add_one && !emit && pend_reg != 8'hff) begin
                pend_reg <= pend_reg + 8'h1;
            end else if (emit && !add_one) begin
                pend_reg <= pend_reg - 8'h1;
            end
        end
    end

    // edge spacing keeps output within the edge rate ceiling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_reg <= '0;
        end else if (emit) begin
            gap_reg <= 8'(EDGE_MIN_CYC - 1);
        end else if (gap_reg != 8'h0) begin
            gap_reg <= gap_reg - 8'h1;
        end
    end

    // quadrature stepping: forward {a,b} 00-10-11-01, a leads b
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            quad_reg <= 2'h0;
        end else if (emit) begin
            case ({dir_reg, quad_reg})
                3'b000: quad_reg <= 2'b10;
                3'b010: quad_reg <= 2'b11;
                3'b011: quad_reg <= 2'b01;
                3'b001: quad_reg <= 2'b00;
                3'b100: quad_reg <= 2'b01;
                3'b101: quad_reg <= 2'b11;
                3'b111: quad_reg <= 2'b10;
                default: quad_reg <= 2'b00;
            endcase
        end
    end

    // index: aligned with a when the scaled resolution is a multiple of 4 and the denominator is one
    logic [RES_W+15:0] scaled;
    logic              synced;
    logic              index_reg;
    logic              index_now;
    assign scaled = res_reg * numer_reg;
    // divisibility by denominator is approximated by denominator equal to one
    assign synced = (scaled[1:0] == 2'b00) && (denom_reg == 16'h1);
    // registered index level from the encoder
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            index_reg <= 1'b0;
        end else begin
            index_reg <= fb_index;
        end
    end
    // gate with the same a state the pin stage registers, so index
    // and phase a leave on one edge and never skew by a cycle
    assign index_now = synced ? (index_reg && quad_reg[1]) : index_reg;

    // output pins registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins <= 7'b0101011;
        end else begin
            pins.pulse_phase_a_pos          <= quad_reg[1];
            pins.pulse_phase_a_neg          <= !quad_reg[1];
            pins.pulse_phase_b_pos          <= quad_reg[0];
            pins.pulse_phase_b_neg          <= !quad_reg[0];
            pins.index_pulse_pos            <= index_now;
            pins.index_pulse_neg            <= !index_now;
            pins.index_pulse_open_collector <= !index_now;
        end
    end

    // axi4-lite write: both channels taken together, then response
    logic aw_ok;
    assign aw_ok         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = aw_ok;
    assign s_axi_wready  = aw_ok;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_first_reg  <= SELECT_RST;
            sel_second_reg <= SELECT_RST;
            latch_reg      <= LATCH_RST;
            mask_reg       <= MASK_RST;
            numer_reg      <= NUMER_RST;
            denom_reg      <= DENOM_RST;
            res_reg        <= RES_W'(1 << 20);
            s_axi_bvalid   <= 1'b0;
            s_axi_bresp    <= RESP_OKAY;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (aw_ok) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OKAY;
                if (s_axi_awaddr == ADDR_SELECT) begin
                    if (s_axi_wstrb[0]) sel_first_reg  <= s_axi_wdata[3:0];
                    if (s_axi_wstrb[1]) sel_second_reg <= s_axi_wdata[11:8];
                end else if (s_axi_awaddr == ADDR_LATCH) begin
                    // values above ten are refused and keep the old time
                    if (s_axi_wstrb[0] && s_axi_wdata[3:0] <= 4'(LATCH_MAX_S)) latch_reg <= s_axi_wdata[3:0];
                end else if (s_axi_awaddr == ADDR_MASK) begin
                    if (s_axi_wstrb[0]) mask_reg[7:0]  <= s_axi_wdata[7:0];
                    if (s_axi_wstrb[1]) mask_reg[10:8] <= s_axi_wdata[10:8];
                end else if (s_axi_awaddr == ADDR_DIVIDE) begin
                    if (s_axi_wstrb[0]) numer_reg[7:0]  <= s_axi_wdata[7:0];
                    if (s_axi_wstrb[1]) numer_reg[15:8] <= s_axi_wdata[15:8];
                    if (s_axi_wstrb[2] && s_axi_wdata[23:16] != 8'h0) denom_reg[7:0] <= s_axi_wdata[23:16];
                    if (s_axi_wstrb[3]) denom_reg[15:8] <= s_axi_wdata[31:24];
                end else if (s_axi_awaddr == ADDR_RES) begin
                    if (&s_axi_wstrb) res_reg <= s_axi_wdata[RES_W-1:0];
                end else if (s_axi_awaddr == ADDR_WSTATUS || s_axi_awaddr == ADDR_OSTATUS) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end
        end
    end

    // axi4-lite read
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= '0;
            if (s_axi_araddr == ADDR_SELECT) begin
                s_axi_rdata <= {20'h0, sel_second_reg, 4'h0, sel_first_reg};
            end else if (s_axi_araddr == ADDR_LATCH) begin
                s_axi_rdata <= {28'h0, latch_reg};
            end else if (s_axi_araddr == ADDR_MASK) begin
                s_axi_rdata <= {21'h0, mask_reg};
            end else if (s_axi_araddr == ADDR_DIVIDE) begin
                s_axi_rdata <= {denom_reg, numer_reg};
            end else if (s_axi_araddr == ADDR_WSTATUS) begin
                s_axi_rdata <= {22'h0, warn_reg};
            end else if (s_axi_araddr == ADDR_OSTATUS) begin
                s_axi_rdata <= {25'h0, stat_out, warning_out_second, warning_out_first};
            end else if (s_axi_araddr == ADDR_RES) begin
                s_axi_rdata <= 32'(res_reg);
            end else begin
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // assertions
    a_overload_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        cond.load_pct >= LOAD_WARN_PCT && !mask_reg[7] |=> warn_reg[W_OVERLOAD])
        else $error("overload not raised");
    a_regen_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        cond.regen_pct >= LOAD_WARN_PCT && !mask_reg[5] |=> warn_reg[W_REGEN])
        else $error("regen not raised");
    a_battery_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        cond.batt_mv <= BATT_WARN_MV && !mask_reg[0] |=> warn_reg[W_BATTERY])
        else $error("battery not raised");
    a_mask_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
        mask_reg[MASK_BIT[W_OSC]] |=> !warn_reg[W_OSC])
        else $error("masked warning seen");
    a_battery_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        warn_reg[W_BATTERY] && !mask_reg[0] ##1 !mask_reg[0] |-> warn_reg[W_BATTERY])
        else $error("battery warning released");
    a_or_select: assert property (@(posedge aclk) disable iff (!aresetn)
        sel_first_reg == 4'h0 |=> warning_out_first == $past(|warn_reg))
        else $error("or select wrong");
    a_servo_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 stat_out.servo_on == $past(stat.servo_on))
        else $error("servo state wrong");
    a_cz_inverse: assert property (@(posedge aclk) disable iff (!aresetn)
        pins.index_pulse_open_collector == pins.index_pulse_neg)
        else $error("open collector index not inverted");
    // cycles since the last output edge, saturating, for the rate check
    logic [7:0] since_emit_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            since_emit_reg <= 8'hff;
        end else if (emit) begin
            since_emit_reg <= 8'h0;
        end else if (since_emit_reg != 8'hff) begin
            since_emit_reg <= since_emit_reg + 8'h1;
        end
    end
    sequence s_edge;
        emit;
    endsequence
    a_edge_rate: assert property (@(posedge aclk) disable iff (!aresetn)
        s_edge |-> since_emit_reg >= 8'(EDGE_MIN_CYC - 1))
        else $error("edge rate exceeded");
    a_quad_step: assert property (@(posedge aclk) disable iff (!aresetn)
        emit |=> $countones(quad_reg ^ $past(quad_reg)) == 1)
        else $error("quadrature broke");
endmodule
`default_nettype wire

/* File: include/warn_pkg.sv */
//Contract
//- overload warning at 85 percent, code 1, bit7
//- regeneration warning at 85 percent, code 2, bit5
//- battery warning at 3.2 V, code 3, bit0
//- fan stopped one second, code 4, bit6
//- communication errors: encoder 5/bit4, scale 10/bit10
//- detector warnings: overheat 6/bit3, scale 9/bit8
//- oscillation warning, code 7, bit9
//- lifetime warning, code 8, bit2
//- latch time 1 to 10 s or unlimited
//- battery and lifetime latch without limit
//- output select code, zero gives OR of all
//- mask bit one suppresses that warning
//- position command active output
//- speed clamped output
//- clearable alarm output
//- speed command active output
//- servo on state output
//- divided A/B/index output, max 4 Mpps
//- open collector index inverted from differential
//- index aligned with A when multiple of 4; code aligns only when the denominator is also 1
package warn_pkg;
    // clock
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          CLK_NS          = 10;
    // pulse output ceiling, edges per second after quadrupling
    localparam int          EDGE_MAX_PPS    = 4_000_000;
    localparam int          EDGE_MIN_CYC    = (CLK_HZ + EDGE_MAX_PPS - 1) / EDGE_MAX_PPS;
    // timing figures
    localparam int          FAN_STOP_MS     = 1000;
    localparam int          FAN_STOP_CYC    = FAN_STOP_MS * (CLK_HZ / 1000);
    localparam int          SEC_CYC         = CLK_HZ;
    localparam int          LATCH_MAX_S     = 10;
    localparam logic [3:0]  LATCH_UNLIMITED = 4'h0;
    // thresholds
    localparam logic [7:0]  LOAD_WARN_PCT   = 8'h55;
    localparam logic [11:0] BATT_WARN_MV    = 12'hc80;
    // warning index = select code minus one; mask bit per warning
    localparam int          NUM_WARN        = 10;
    localparam int          W_OVERLOAD      = 0;
    localparam int          W_REGEN         = 1;
    localparam int          W_BATTERY       = 2;
    localparam int          W_FAN           = 3;
    localparam int          W_ENC_COMM      = 4;
    localparam int          W_ENC_HEAT      = 5;
    localparam int          W_OSC           = 6;
    localparam int          W_LIFE          = 7;
    localparam int          W_SCALE_ERR     = 8;
    localparam int          W_SCALE_COMM    = 9;
    localparam int          MASK_BIT [NUM_WARN] = '{7, 5, 0, 6, 4, 3, 9, 2, 8, 10};
    // axi register offsets
    localparam logic [7:0]  ADDR_SELECT     = 8'h00;
    localparam logic [7:0]  ADDR_LATCH      = 8'h04;
    localparam logic [7:0]  ADDR_MASK       = 8'h08;
    localparam logic [7:0]  ADDR_DIVIDE     = 8'h0c;
    localparam logic [7:0]  ADDR_WSTATUS    = 8'h10;
    localparam logic [7:0]  ADDR_OSTATUS    = 8'h14;
    localparam logic [7:0]  ADDR_RES        = 8'h18;
    // reset values
    localparam logic [3:0]  SELECT_RST      = 4'h0;
    localparam logic [3:0]  LATCH_RST       = 4'h1;
    localparam logic [10:0] MASK_RST        = 11'h000;
    localparam logic [15:0] NUMER_RST       = 16'h0001;
    localparam logic [15:0] DENOM_RST       = 16'h0001;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // raw condition inputs from the control core
    typedef struct packed {
        logic [7:0]  load_pct;
        logic [7:0]  regen_pct;
        logic [11:0] batt_mv;
        logic        fan_stopped;
        logic        enc_comm_over;
        logic        enc_overheat;
        logic        osc_detected;
        logic        life_short;
        logic        scale_alarm;
        logic        scale_comm_over;
    } warn_cond_t;
    // status conditions
    typedef struct packed {
        logic pos_cmd;
        logic speed_limit;
        logic alarm_clearable;
        logic speed_cmd;
        logic servo_on;
    } drive_stat_t;
    // output pins
    typedef struct packed {
        logic pulse_phase_a_pos;
        logic pulse_phase_a_neg;
        logic pulse_phase_b_pos;
        logic pulse_phase_b_neg;
        logic index_pulse_pos;
        logic index_pulse_neg;
        logic index_pulse_open_collector;
    } pulse_pins_t;
endpackage

/* File: verif/quad_host.sv */
`timescale 1ns/100ps
`default_nettype none
module quad_host
    import warn_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // pins of the drive
    input  wire pulse_pins_t pins,
    // tallies for the bench
    output var int           pos,
    output var int           errs
);
    logic [1:0] ab_reg;  // last sampled a/b
    logic       a;       // phase a now
    logic       b;       // phase b now
    assign a = pins.pulse_phase_a_pos;
    assign b = pins.pulse_phase_b_pos;
    // host counter; a leading counts up, a double step is a fault
    always_ff @(posedge aclk) begin
        ab_reg <= {a, b};
        if (!aresetn) begin
            pos  <= 0;
            errs <= 0;
        end else begin
            case ({ab_reg, a, b})
                4'h2, 4'hb, 4'hd, 4'h4: pos <= pos + 1;
                4'h1, 4'h7, 4'he, 4'h8: pos <= pos - 1;
                4'h3, 4'hc, 4'h6, 4'h9: errs <= errs + 1;
                default: ;
            endcase
            // pin pairs and index polarity; index is never trusted alone
            if (pins.pulse_phase_a_neg !== ~a || pins.pulse_phase_b_neg !== ~b ||
                pins.index_pulse_neg !== ~pins.index_pulse_pos ||
                pins.index_pulse_open_collector !== pins.index_pulse_neg ||
                (pins.index_pulse_pos && !a)) begin
                errs <= errs + 1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/warning_status_pulse_outputs_test.sv */
`timescale 1ns/100ps
`default_nettype none
module warning_status_pulse_outputs_test;
    import warn_pkg::*;
    localparam int SEC_T = 10;  // shortened second
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, w1, w2;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0] bresp, rresp, rsp;
    warn_cond_t cond = '0;
    drive_stat_t stat = '0, stat_out;
    logic fb_step = 1'b0, fb_dir = 1'b0, fb_index = 1'b0;
    pulse_pins_t pins;
    int n_errors = 0, n_checks = 0, cyc = 0, pos, perrs, seed = 89577, n, p0;
    warning_status_pulse_outputs #(.FAN_CYC(20), .SEC_CNT(SEC_T)) warning_status_pulse_outputs_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cond(cond), .stat(stat),
        .fb_step(fb_step), .fb_dir(fb_dir), .fb_index(fb_index), .warning_out_first(w1),
        .warning_out_second(w2), .stat_out(stat_out), .pins(pins));
    quad_host quad_host_i (.aclk(aclk), .aresetn(aresetn), .pins(pins), .pos(pos), .errs(perrs));
    always #5 aclk = ~aclk;
    // hang guard, well above the few thousand cycles needed
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            test_done();
        end
    end
    // all causes absent; battery well above its threshold
    function automatic warn_cond_t quiet();
        warn_cond_t q = '0;
        q.batt_mv = 12'hfff;
        return q;
    endfunction
    // one cause at its exact threshold
    function automatic warn_cond_t cause(input int i);
        warn_cond_t c = quiet();
        case (i)
            W_OVERLOAD: c.load_pct = LOAD_WARN_PCT;
            W_REGEN: c.regen_pct = LOAD_WARN_PCT;
            W_BATTERY: c.batt_mv = BATT_WARN_MV;
            W_FAN: c.fan_stopped = 1'b1;
            W_ENC_COMM: c.enc_comm_over = 1'b1;
            W_ENC_HEAT: c.enc_overheat = 1'b1;
            W_OSC: c.osc_detected = 1'b1;
            W_LIFE: c.life_short = 1'b1;
            W_SCALE_ERR: c.scale_alarm = 1'b1;
            default: c.scale_comm_over = 1'b1;
        endcase
        return c;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // axi4-lite write, address and data offered together
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        @(posedge aclk);
        while (!(awready && wready)) @(posedge aclk);
        awvalid <= 1'b0; wvalid <= 1'b0; bready <= 1'b1;
        @(posedge aclk);
        while (!bvalid) @(posedge aclk);
        rsp = bresp; bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1;
        @(posedge aclk);
        while (!arready) @(posedge aclk);
        arvalid <= 1'b0; rready <= 1'b1;
        @(posedge aclk);
        while (!rvalid) @(posedge aclk);
        rd = rdata; rsp = rresp; rready <= 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        cond = quiet();
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(ADDR_DIVIDE); chk(rd, {DENOM_RST, NUMER_RST});
        rd_reg(8'h1c); chk(32'(rsp), 32'(RESP_SLVERR));
        wr_reg(ADDR_LATCH, 32'h0000_000b); rd_reg(ADDR_LATCH); chk(rd, 32'(LATCH_RST));
        // status copies, random patterns
        repeat (8) begin
            stat <= 5'($random(seed));
            repeat (2) @(posedge aclk);
            chk(32'(stat_out), 32'(stat));
        end
        // every warning: raise, route, latch, mask; odd ones latch without limit
        for (int i = 0; i < NUM_WARN; i++) begin
            wr_reg(ADDR_LATCH, (i % 2) ? 32'h0 : 32'h1);
            wr_reg(ADDR_SELECT, (i % 2) ? 32'(i + 1) : 32'(i + 1) << 8);
            cond <= cause(i);
            repeat (30) @(posedge aclk);
            chk({w2, w1}, 2'b11);
            rd_reg(ADDR_WSTATUS); chk(rd, 32'h1 << i);
            cond <= quiet();
            repeat (3 * SEC_T + 5) @(posedge aclk);
            chk(w1, (i % 2) || i == W_BATTERY || i == W_LIFE);
            wr_reg(ADDR_MASK, 32'h1 << MASK_BIT[i]);
            cond <= cause(i);
            repeat (30) @(posedge aclk);
            chk({w2, w1}, 2'b00);
            cond <= quiet();
            wr_reg(ADDR_MASK, 32'h0);
        end
        // pulse bursts both ways, index held high on the second
        for (int d = 0; d < 2; d++) begin
            fb_dir <= d[0]; fb_index <= d[0];
            n = 4 + ($random(seed) & 7);
            repeat (40) @(posedge aclk);
            p0 = pos;
            repeat (n) begin
                fb_step <= 1'b1;
                @(posedge aclk);
                fb_step <= 1'b0;
                repeat (30) @(posedge aclk);
            end
            repeat (60) @(posedge aclk);
            chk(pos - p0, d ? -n : n);
        end
        chk(perrs, 0);
        test_done();
    end
endmodule
`default_nettype wire
